// ==== shared/dsp_pipe_pkg.sv ====
// Constants and carrier types for the DSP operation pipeline sequencer.
// Assumes a single core clock and a synchronous active-low core reset.
// Operation
// (RL1) Every DSP arithmetic, logical, shift and register-transfer operation passes fetch, decode, execute, memory access and DSP write-back.
// (RL2) A conditional DSP operation whose condition is false skips its write-back, so no destination register changes.
// (RL3) Such a false-condition operation still takes the same five slots, with no added stall or bubble.
// (RL4) The signed multiply moves through the same five stages as the other DSP operations.
// (RL5) Contention is flagged when a DSP-register to MAC-half transfer issues together with a parallel memory load.
// (RL6) Contention is flagged when a DSP memory store directly follows a DSP-register to MAC-half transfer.
// (RL7) Contention is flagged when a store writes out a DSP result in the instruction right after that DSP operation.
// (RL8) On contention the later instruction stalls until the resource is free, keeping program-order results.
package dsp_pipe_pkg;

   // ************************************************************
   // Pipeline shape
   // ************************************************************
   localparam int NUM_STAGES    = 5;
   localparam int ST_FETCH      = 0;
   localparam int ST_DECODE     = 1;
   localparam int ST_EXEC       = 2;
   localparam int ST_MEM        = 3;
   localparam int ST_WB         = 4;
   // Stall cycles added after the hazard cycle for one contention
   localparam logic [1:0] STALL_CYCLES = 2'h1;
   localparam int REG_IDX_W     = 4;

   // ************************************************************
   // Operation classes and condition modes
   // ************************************************************
   typedef enum logic [2:0] {
      OP_NONE, OP_ALU_ARITH, OP_ALU_LOGIC, OP_SHIFT,
      OP_SIGNED_MUL, OP_READ_MAC, OP_WRITE_MAC
   } op_class_t;

   typedef enum logic [1:0] {
      COND_ALWAYS, EXEC_IF_TRUE, EXEC_IF_FALSE
   } cond_mode_t;

   typedef enum logic [1:0] {
      MEM_NONE, MEM_LOAD, MEM_STORE
   } mem_kind_t;

   // One issued instruction word as seen by the sequencer
   typedef struct packed {
      logic                 valid;
      op_class_t            op;
      cond_mode_t           cond;
      logic [REG_IDX_W-1:0] dst;
      mem_kind_t            mem;
      logic [REG_IDX_W-1:0] store_src;
   } issue_t;

   // Write-back command to the DSP register file
   typedef struct packed {
      logic                 en;
      op_class_t            op;
      logic [REG_IDX_W-1:0] dst;
   } wb_cmd_t;

endpackage

// ==== rtl/dsp_contention_detect.sv ====
// Contention detector for DSP register transfers and memory moves.
// Assumes the issue word is held stable while the sequencer stalls it.
`timescale 1ns/1ps
module dsp_contention_detect (
   // Instruction entering decode and the one ahead of it
   input  wire dsp_pipe_pkg::issue_t incoming,
   input  wire dsp_pipe_pkg::issue_t ahead,
   // Contention causes
   output wire logic                 mac_par_load,
   output wire logic                 mac_then_store,
   output wire logic                 result_store
);
   import dsp_pipe_pkg::*;

   // ************************************************************
   // Decode of hazard cases
   // ************************************************************
   wire logic ahead_mac_xfer;
   wire logic in_mac_xfer;
   wire logic ahead_dsp_result;

   assign in_mac_xfer    = incoming.valid &&
                           (incoming.op == OP_READ_MAC || incoming.op == OP_WRITE_MAC);
   assign ahead_mac_xfer = ahead.valid &&
                           (ahead.op == OP_READ_MAC || ahead.op == OP_WRITE_MAC);
   assign ahead_dsp_result = ahead.valid && ahead.op != OP_NONE;

   // Transfer paired with a load in the same issue slot
   assign mac_par_load   = in_mac_xfer && incoming.mem == MEM_LOAD;          // [RL5]
   // Store right behind a MAC transfer
   assign mac_then_store = incoming.valid && incoming.mem == MEM_STORE
                           && ahead_mac_xfer;                                // [RL6]
   // Store reading the result of the operation just ahead
   assign result_store   = incoming.valid && incoming.mem == MEM_STORE
                           && ahead_dsp_result
                           && incoming.store_src == ahead.dst;               // [RL7]

endmodule // dsp_contention_detect

// ==== rtl/dsp_op_pipeline_control.sv ====
// Five-stage sequencer for DSP data-operation instructions.
// Assumes the fetch side holds its word while issue_ready is low and that
// the condition flag is valid when an operation reaches execute.
`timescale 1ns/1ps
module dsp_op_pipeline_control (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // Issue side
   input  wire dsp_pipe_pkg::issue_t issue,
   output wire logic                 issue_ready,
   // Condition flag from the DSP status
   input  wire logic                 cond_flag,
   // Stage occupancy and write-back
   output logic [4:0]                stage_busy,
   output dsp_pipe_pkg::wb_cmd_t     wb_cmd,
   output logic                      contention
);
   import dsp_pipe_pkg::*;

   // ************************************************************
   // Stage registers
   // ************************************************************
   issue_t     stage [NUM_STAGES];
   logic       cond_ok_mem;
   logic       cond_ok_wb;
   logic [1:0] stall_cnt;
   // Set once the held word in fetch has raised its contention, before its stall slot
   logic       stall_served;

   wire logic  any_cause;
   wire logic  mac_par_load;
   wire logic  mac_then_store;
   wire logic  result_store;
   wire logic  hazard;
   wire logic  stalling;
   wire logic  cond_pass;
   wire issue_t bubble;

   dsp_contention_detect u_detect (
      .incoming       (stage[ST_FETCH]),
      .ahead          (stage[ST_DECODE]),
      .mac_par_load   (mac_par_load),
      .mac_then_store (mac_then_store),
      .result_store   (result_store)
   );

   // ************************************************************
   // Stall control
   // ************************************************************
   // A single stall slot lets the conflicting resource free up; the served
   // flag keeps the held word from raising the same contention forever
   assign any_cause   = mac_par_load || mac_then_store || result_store;
   assign hazard      = any_cause && stall_cnt == 2'h0 && !stall_served;     // [RL8]
   assign stalling    = hazard || stall_cnt != 2'h0;
   assign issue_ready = !stalling;
   assign bubble      = '0;

   // Condition check in execute; false condition only kills write-back
   assign cond_pass = (stage[ST_EXEC].cond == COND_ALWAYS) ||
                      (stage[ST_EXEC].cond == EXEC_IF_TRUE  &&  cond_flag) ||
                      (stage[ST_EXEC].cond == EXEC_IF_FALSE && !cond_flag);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         stall_cnt <= 2'h0;
      end else if (hazard) begin
         stall_cnt <= STALL_CYCLES;                                          // [RL8]
      end else if (stall_cnt != 2'h0) begin
         stall_cnt <= stall_cnt - 2'h1;
      end
   end

   // Set on the hazard cycle, cleared once fetch takes a new word
   always_ff @(posedge clk) begin
      if (!rstn) begin
         stall_served <= 1'b0;
      end else if (hazard) begin
         stall_served <= 1'b1;                                               // [RL8]
      end else if (!stalling) begin
         stall_served <= 1'b0;
      end
   end

   // ************************************************************
   // Stage advance: fetch, decode, execute, memory, write-back
   // ************************************************************
   // Only the dependent word in fetch waits; the older word in decode moves
   // on and a bubble fills decode, so nothing ahead of the conflict is delayed
   // and results stay in program order
   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_STAGES; i++) begin
            stage[i] <= '0;
         end
      end else begin
         if (!stalling) begin
            stage[ST_FETCH]  <= issue;                                       // [RL1]
         end
         stage[ST_DECODE] <= stalling ? bubble : stage[ST_FETCH];            // [RL8]
         stage[ST_EXEC]   <= stage[ST_DECODE];
         stage[ST_MEM]  <= stage[ST_EXEC];   // Multiply takes the same path [RL4]
         stage[ST_WB]   <= stage[ST_MEM];    // False condition still advances [RL3]
      end
   end

   // Condition result travels beside the instruction
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cond_ok_mem <= 1'b0;
         cond_ok_wb  <= 1'b0;
      end else begin
         cond_ok_mem <= cond_pass;
         cond_ok_wb  <= cond_ok_mem;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   generate
      for (genvar g = 0; g < NUM_STAGES; g++) begin : g_busy
         always_ff @(posedge clk) begin
            if (!rstn) begin
               stage_busy[g] <= 1'b0;
            end else begin
               stage_busy[g] <= stage[g].valid;
            end
         end
      end
   endgenerate

   // Write-back issued only for a passing condition
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wb_cmd     <= '0;
         contention <= 1'b0;
      end else begin
         wb_cmd.en  <= stage[ST_WB].valid && stage[ST_WB].op != OP_NONE
                       && cond_ok_wb;                                        // [RL2]
         wb_cmd.op  <= stage[ST_WB].op;
         wb_cmd.dst <= stage[ST_WB].dst;
         contention <= hazard;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   sequence s_mem_reaches_wb;
      stage[ST_MEM].valid ##1 stage[ST_WB].valid;
   endsequence

   a_five_stage_flow: assert property (@(posedge clk) disable iff (!rstn) // [RL1]
      stage[ST_EXEC].valid |=> s_mem_reaches_wb)
      else $error("execute entry did not reach write-back");

   a_false_no_wb: assert property (@(posedge clk) disable iff (!rstn) // [RL2]
      (stage[ST_EXEC].valid && !cond_pass) |-> ##3 !wb_cmd.en)
      else $error("write-back fired for false condition");

   a_false_no_bubble: assert property (@(posedge clk) disable iff (!rstn) // [RL3]
      (stage[ST_EXEC].valid && !cond_pass && !stalling) |=> stage[ST_MEM].valid)
      else $error("false condition changed pipeline timing");

   a_mul_same_path: assert property (@(posedge clk) disable iff (!rstn) // [RL4]
      (stage[ST_EXEC].valid && stage[ST_EXEC].op == OP_SIGNED_MUL) |-> ##2
      (stage[ST_WB].op == OP_SIGNED_MUL))
      else $error("multiply left the five-stage path");

   a_par_load_stall: assert property (@(posedge clk) disable iff (!rstn) // [RL5]
      (mac_par_load && stall_cnt == 2'h0 && !stall_served) |-> !issue_ready ##1 contention)
      else $error("parallel load contention missed");

   a_mac_store_stall: assert property (@(posedge clk) disable iff (!rstn) // [RL6]
      (mac_then_store && stall_cnt == 2'h0 && !stall_served) |-> !issue_ready ##1 contention)
      else $error("store after transfer not stalled");

   a_result_store: assert property (@(posedge clk) disable iff (!rstn) // [RL7]
      (result_store && stall_cnt == 2'h0 && !stall_served)
      |=> !stage[ST_DECODE].valid && stage[ST_FETCH] == $past(stage[ST_FETCH]))
      else $error("result store not held back");

   // ************************************************************
   // Stall and write-back checks
   // ************************************************************
   // Hazard cycle, one stall slot, then the held word is free to go
   sequence s_stall_slot;
      (!hazard && stalling) ##1 !stalling;
   endsequence

   // The word ahead of the conflict keeps its normal pace
   sequence s_older_moves;
      stage[ST_EXEC] == $past(stage[ST_DECODE]) ##1
      stage[ST_MEM] == $past(stage[ST_DECODE], 2);
   endsequence

   a_stall_bounded: assert property (@(posedge clk) disable iff (!rstn) // [RL8]
      hazard |=> s_stall_slot)
      else $error("stall length wrong");

   a_older_moves_on: assert property (@(posedge clk) disable iff (!rstn) // [RL8]
      hazard |=> s_older_moves)
      else $error("older word delayed by stall");

   a_fetch_held: assert property (@(posedge clk) disable iff (!rstn) // [RL8]
      stalling |=> stage[ST_FETCH] == $past(stage[ST_FETCH]))
      else $error("stalled word left fetch");

   a_stall_bubble: assert property (@(posedge clk) disable iff (!rstn) // [RL8]
      stalling |=> !stage[ST_DECODE].valid)
      else $error("no bubble behind stalled word");

   a_contention_pulse: assert property (@(posedge clk) disable iff (!rstn) // [RL8]
      hazard |=> contention ##1 !contention)
      else $error("contention pulse wrong");

   a_wb_needs_pass: assert property (@(posedge clk) disable iff (!rstn) // [RL2]
      wb_cmd.en |-> $past(cond_ok_wb) && $past(stage[ST_WB].valid))
      else $error("write-back without passing condition");

endmodule // dsp_op_pipeline_control

// ==== tb/tb_top.sv ====
// Self-checking bench for the DSP operation pipeline sequencer.
// Assumes the sequencer carries its own assertions and that one core clock drives it.
`timescale 1ns/1ps
module tb_top;
   import dsp_pipe_pkg::*;
   // ************************************************************
   // Stimulus, design and logs
   // ************************************************************
   logic        clk       = 1'b0;
   logic        rstn      = 1'b0;
   issue_t      issue     = '0;
   logic        cond_flag = 1'b0;
   wire logic   issue_ready;
   logic [4:0]  stage_busy;
   wb_cmd_t     wb_cmd;
   logic        contention;
   int          cyc       = 0;
   int          bad_count = 0;
   int          tests_run = 0;
   int          cont_n    = 0;
   int          caps[$];
   int          wb_cyc[$];
   logic [3:0]  wb_dst[$];
   op_class_t   wb_op[$];

   dsp_op_pipeline_control uut (
      .clk(clk), .rstn(rstn), .issue(issue), .issue_ready(issue_ready), .cond_flag(cond_flag),
      .stage_busy(stage_busy), .wb_cmd(wb_cmd), .contention(contention));

   // Free-running 100 MHz clock
   initial forever #5 clk = ~clk;

   // Cycle count with a ceiling well above the whole run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count++;
         give_verdict();
      end
   end

   // Outputs are logged at the falling edge, where they are settled
   always @(negedge clk) begin
      if (rstn === 1'b1 && wb_cmd.en === 1'b1) begin
         wb_cyc.push_back(cyc);
         wb_dst.push_back(wb_cmd.dst);
         wb_op.push_back(wb_cmd.op);
      end
      if (rstn === 1'b1 && contention === 1'b1) cont_n++;
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   function automatic issue_t mk(op_class_t op, cond_mode_t c, logic [3:0] d, mem_kind_t m,
                                 logic [3:0] s);
      mk = '{1'b1, op, c, d, m, s};
   endfunction

   // Issues words back to back, holding each while refused; cap is the capturing edge
   task automatic run(input issue_t prog[$]);
      int n;
      caps.delete();
      wb_cyc.delete();
      wb_dst.delete();
      wb_op.delete();
      cont_n = 0;
      foreach (prog[i]) begin
         @(posedge clk);
         issue <= prog[i];
         n = 0;
         @(negedge clk);
         while (issue_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
         end
         caps.push_back(cyc + 1);
      end
      @(posedge clk);
      issue <= '0;
      repeat (14) @(posedge clk);
   endtask

   // Pair a, b then a plain word: the stall shows as the plain word's refusal
   task automatic hazard(input issue_t a, input issue_t b, input int cont, input int gap);
      run('{a, b, mk(OP_ALU_LOGIC, COND_ALWAYS, 4'hC, MEM_NONE, 0)});
      check("contention count", cont_n, cont);
      check("issue gap", caps[2] - caps[1], gap);
      check("first wb cycle", wb_cyc.size() > 0 ? wb_cyc[0] : 0, caps[0] + 5);
      check("last wb cycle", wb_cyc.size() > 0 ? wb_cyc[$] : 0, caps[2] + 5);
      check("last wb dst", wb_dst.size() > 0 ? wb_dst[$] : 4'h0, 4'hC);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   // Arithmetic, logic, shift and multiply back to back: each writes back five cycles after capture
   task automatic t_flow();
      op_class_t ops[4] = '{OP_ALU_ARITH, OP_ALU_LOGIC, OP_SHIFT, OP_SIGNED_MUL};
      run('{mk(OP_ALU_ARITH, COND_ALWAYS, 1, MEM_NONE, 0), mk(OP_ALU_LOGIC, COND_ALWAYS, 2, MEM_NONE, 0),
            mk(OP_SHIFT, COND_ALWAYS, 3, MEM_NONE, 0), mk(OP_SIGNED_MUL, COND_ALWAYS, 4, MEM_NONE, 0)});
      check("wb count", wb_cyc.size(), 4);
      check("issue span", caps[3] - caps[0], 3);
      for (int i = 0; i < 4 && i < wb_cyc.size(); i++) begin
         check("wb cycle", wb_cyc[i], caps[i] + 5);
         check("wb dst", wb_dst[i], i + 1);
         check("wb op", wb_op[i], ops[i]);
      end
      check("pipe empty", stage_busy, 5'h00);
   endtask

   // Failing conditions drop the write-back but keep slot timing
   task automatic t_cond();
      cond_flag <= 1'b0;
      run('{mk(OP_ALU_ARITH, EXEC_IF_TRUE, 2, MEM_NONE, 0), mk(OP_SHIFT, COND_ALWAYS, 3, MEM_NONE, 0),
            mk(OP_READ_MAC, EXEC_IF_FALSE, 4, MEM_NONE, 0)});
      check("wb count", wb_cyc.size(), 2);
      check("issue span", caps[2] - caps[0], 2);
      if (wb_cyc.size() == 2) begin
         check("wb dst", wb_dst[0], 3);
         check("wb cycle", wb_cyc[0], caps[1] + 5);
         check("wb dst", wb_dst[1], 4);
      end
      cond_flag <= 1'b1;
      run('{mk(OP_ALU_LOGIC, EXEC_IF_TRUE, 5, MEM_NONE, 0), mk(OP_ALU_LOGIC, EXEC_IF_FALSE, 6, MEM_NONE, 0)});
      check("wb count", wb_cyc.size(), 1);
      check("wb dst", wb_dst.size() > 0 ? wb_dst[0] : 4'hF, 5);
   endtask

   task automatic t_mac_load();
      hazard(mk(OP_ALU_ARITH, COND_ALWAYS, 1, MEM_NONE, 0),
             mk(OP_WRITE_MAC, COND_ALWAYS, 2, MEM_LOAD, 0), 1, 3);
   endtask

   task automatic t_mac_store();
      hazard(mk(OP_WRITE_MAC, COND_ALWAYS, 1, MEM_NONE, 0),
             mk(OP_NONE, COND_ALWAYS, 0, MEM_STORE, 9), 1, 3);
   endtask

   // Matching source stalls, a different source flows straight on
   task automatic t_result_store();
      hazard(mk(OP_ALU_ARITH, COND_ALWAYS, 7, MEM_NONE, 0),
             mk(OP_NONE, COND_ALWAYS, 0, MEM_STORE, 7), 1, 3);
      hazard(mk(OP_ALU_ARITH, COND_ALWAYS, 7, MEM_NONE, 0),
             mk(OP_NONE, COND_ALWAYS, 0, MEM_STORE, 8), 0, 1);
   endtask

   // One word walks the occupancy bits from fetch to write-back
   task automatic t_busy();
      @(posedge clk);
      issue <= mk(OP_SHIFT, COND_ALWAYS, 5, MEM_NONE, 0);
      @(posedge clk);
      issue <= '0;
      for (int k = 0; k < 5; k++) begin
         @(posedge clk);
         @(negedge clk);
         check("stage busy", stage_busy, 5'h01 << k);
      end
      repeat (4) @(posedge clk);
   endtask

   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Main sequence: reset held for 16 edges, outputs checked while held
   initial begin
      repeat (15) @(posedge clk);
      @(negedge clk);
      check("reset ready", issue_ready, 1'b1);
      check("reset busy", stage_busy, 5'h00);
      check("reset wb", wb_cmd.en, 1'b0);
      @(posedge clk);
      rstn <= 1'b1;
      t_flow();
      t_cond();
      t_mac_load();
      t_mac_store();
      t_result_store();
      t_busy();
      give_verdict();
   end
endmodule // tb_top
